// File: shared/crg_pkg.sv
// Purpose: Types shared by the clock and reset generator.
// Assumes: crg_regs.svh supplies the widths.
// Notes:   All state of the top module is one packed struct.
`include "crg_regs.svh"

package crg_pkg;

  typedef enum logic [1:0] {
    CRG_OFF,
    CRG_HOLD,
    CRG_RUN,
    CRG_HARD
  } crg_seq_type;

  // One I/O cycle toward the reset control port.
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } crg_io_req_type;

  // Reset and initialization outputs.
  typedef struct packed {
    logic cpu_reset_out;
    logic pci_reset_out_n;
    logic expansion_bus_reset_out;
    logic cpu_init_out;
  } crg_rst_out_type;

  typedef struct packed {
    crg_seq_type seq;
    logic pg_meta;
    logic pg_sync;
    logic pg_seen;
    logic tristate;
    logic pci_clk;
    logic rtc_en;
    logic rtc_gated;
    logic [`CRG_CNT_W-1:0] cnt;
    logic [`CRG_INIT_W-1:0] init_cnt;
    logic [7:0] rdata;
    crg_rst_out_type rst;
  } crg_state_type;

endpackage : crg_pkg

// File: shared/crg_regs.svh
// Purpose: Offsets, field positions, reset values and timing figures of the
//          clock and reset generator.
// Assumes: Register reached by 8-bit I/O cycles at its fixed port address.
// Notes:   Definitions only.
`ifndef CRG_REGS_SVH
`define CRG_REGS_SVH

// Reset control port and its fields.
`define CRG_RC_ADDR 16'h0CF9
`define CRG_RC_RESET 8'h00
`define CRG_RC_SOFT_BIT 0
`define CRG_RC_HARD_BIT 1
`define CRG_RC_RTC_EN_BIT 2
`define CRG_RC_BUSY_BIT 7

// Host clock rate and minimum reset duration.
`define CRG_CLK_MHZ 40
`define CRG_RST_MIN_US 1000
// Highest supported PCI clock, used to size the reset counter.
`define CRG_PCI_MAX_MHZ 33
`define CRG_CNT_W 16

// Length of the CPU initialization pulse, in PCI clocks.
`define CRG_INIT_PCI_CYCLES 16
`define CRG_INIT_W 5

`endif

// File: verification/crg_chk.sv
// Purpose: Port checker of the clock and reset generator.
// Assumes: Bench sets RST_PCI_CYCLES to 8 or more.
// Notes: Bound to crg_top.
`timescale 1ns/100ps
`default_nettype none
module crg_chk #(
  // Shortest legal PCI reset low time, in clk cycles.
  parameter int MIN_LOW = 16
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Observed ports.
  input wire logic power_good,
  input wire logic rtc_clock_in,
  input wire logic shutdown_cycle,
  input wire crg_pkg::crg_io_req_type io_req,
  input wire logic pci_clock_out,
  input wire logic rtc_clock_gated_out,
  input wire crg_pkg::crg_rst_out_type rst_out,
  input wire logic regs_default_out
);
  import crg_pkg::*;
  logic run_wr;
  assign run_wr = io_req.wr && io_req.addr == 16'h0CF9 && !regs_default_out;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Consecutive clk cycles with PCI reset low, saturating at the minimum.
  int low_cnt;
  always_ff @(posedge clk) begin
    if (!nrst || rst_out.pci_reset_out_n) begin
      low_cnt <= 0;
    end else if (low_cnt < MIN_LOW) begin
      low_cnt <= low_cnt + 1;
    end
  end
  property p_pclk; 1 |=> pci_clock_out != $past(pci_clock_out); endproperty
  a_pclk: assert property (p_pclk) else $error("pci clock not clk/2");
  property p_rtc; rtc_clock_gated_out |-> $past(rtc_clock_in); endproperty
  a_rtc: assert property (p_rtc) else $error("rtc out without input");
  property p_pglow;
    !power_good [*6] |-> !rst_out.pci_reset_out_n && rst_out.cpu_reset_out
      && rst_out.expansion_bus_reset_out;
  endproperty
  a_pglow: assert property (p_pglow) else $error("resets not held");
  property p_same;
    $rose(rst_out.pci_reset_out_n) |-> !rst_out.cpu_reset_out
      && !rst_out.expansion_bus_reset_out;
  endproperty
  a_same: assert property (p_same) else $error("resets not released together");
  property p_hard;
    run_wr && io_req.wdata[1] |=> !rst_out.pci_reset_out_n
      && rst_out.expansion_bus_reset_out && regs_default_out;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset not started");
  property p_cpu; run_wr && io_req.wdata[1] |-> ##[2:3] rst_out.cpu_reset_out; endproperty
  a_cpu: assert property (p_cpu) else $error("cpu reset missing");
  property p_min; $fell(rst_out.pci_reset_out_n) |-> !rst_out.pci_reset_out_n [*8]; endproperty
  a_min: assert property (p_min) else $error("pci reset too short");
  property p_minlen; $rose(rst_out.pci_reset_out_n) |-> low_cnt >= MIN_LOW; endproperty
  a_minlen: assert property (p_minlen) else $error("pci reset below minimum");
  property p_soft; run_wr && io_req.wdata[1:0] == 2'b01 |=> rst_out.cpu_init_out; endproperty
  a_soft: assert property (p_soft) else $error("soft reset no init");
  property p_shut;
    shutdown_cycle && !regs_default_out && !(run_wr && io_req.wdata[1])
      |=> rst_out.cpu_init_out;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown no init");
  property p_csync;
    $changed(rst_out.cpu_reset_out) |-> $rose(pci_clock_out);
  endproperty
  a_csync: assert property (p_csync) else $error("cpu reset off pci edge");
  c_rel: cover property ($rose(rst_out.pci_reset_out_n));
  c_hard: cover property (run_wr && io_req.wdata[1]);
  c_init: cover property ($rose(rst_out.cpu_init_out));
endmodule : crg_chk
bind crg_top crg_chk #(.MIN_LOW(2 * RST_PCI_CYCLES)) u_chk (.clk(clk), .nrst(nrst),
  .power_good(power_good),
  .rtc_clock_in(rtc_clock_in), .shutdown_cycle(shutdown_cycle), .io_req(io_req),
  .pci_clock_out(pci_clock_out), .rtc_clock_gated_out(rtc_clock_gated_out),
  .rst_out(rst_out), .regs_default_out(regs_default_out));
`default_nettype wire

// File: verification/crg_supply.sv
// Purpose: Power supervisor model that drives power_good.
// Assumes: good_req says supply and PCI clock are stable.
// Notes: Output edges fall off the host clock grid on purpose.
`timescale 1ns/100ps
`default_nettype none
module crg_supply (
  // Request from the bench.
  input wire logic good_req,
  // Supervisor output.
  output logic power_good
);
  initial power_good = 1'b0;
  always @(good_req) power_good <= #7.3 good_req;
endmodule : crg_supply
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench of the clock and reset generator.
// Assumes: Inputs change 1 ns after the rising clock edge, except power_good, which follows good_req 7.3 ns later.
// Notes: Reset hold shortened to 8 PCI clocks.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import crg_pkg::*;
  logic clk, nrst, good_req, power_good, strap_n, rtc_in, shut;
  logic hclk, pclk, rtc_out, regs_def, oe;
  logic [7:0] io_rdata;
  crg_io_req_type io_req;
  crg_rst_out_type rst_out;
  int fails, n_compared, n;
  int cyc, c0, c_wr;
  crg_top #(.RST_PCI_CYCLES(8)) u_dut (.clk(clk), .nrst(nrst), .power_good(power_good),
    .tristate_test_in_n(strap_n), .rtc_clock_in(rtc_in), .shutdown_cycle(shut),
    .io_req(io_req), .io_rdata(io_rdata), .host_clock_out(hclk), .pci_clock_out(pclk),
    .rtc_clock_gated_out(rtc_out), .rst_out(rst_out), .regs_default_out(regs_def),
    .outputs_oe(oe));
  crg_supply u_sup (.good_req(good_req), .power_good(power_good));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  ////////////////////////////////////////
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] d);
    io_req = '{16'h0CF9, 1'b1, 1'b0, d};
    tick(1);
    c_wr = cyc;
    io_req = '0;
    tick(1);
  endtask : wr
  task rd(input logic [15:0] a, input logic [7:0] exp);
    io_req = '{a, 1'b0, 1'b1, 8'h00};
    tick(1);
    io_req = '0;
    cmp(io_rdata, exp);
    tick(1);
  endtask : rd
  task wait_rel;
    n = 0;
    while (rst_out.pci_reset_out_n !== 1'b1 && n < 500) begin
      tick(1);
      n++;
    end
  endtask : wait_rel
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #(25 * 3000);
    fails++;
    finish_test;
  end
  initial begin
    nrst = 1'b0;
    good_req = 1'b0;
    strap_n = 1'b1;
    rtc_in = 1'b0;
    shut = 1'b0;
    io_req = '0;
    tick(12);
    nrst = 1'b1;
    tick(4);
    cmp({4'h0, rst_out}, 8'h0A);
    good_req = 1'b1;
    c0 = cyc;
    wait_rel;
    cmp(8'(cyc - c0 >= 16 && cyc - c0 <= 22), 8'h01);
    cmp({4'h0, rst_out}, 8'h04);
    cmp({7'h00, regs_def}, 8'h00);
    rd(16'h0CF9, 8'h00);
    wr(8'h04);
    rd(16'h0CF9, 8'h04);
    rd(16'h0CF8, 8'h00);
    rtc_in = 1'b1;
    tick(2);
    cmp({hclk, 6'h00, rtc_out}, 8'h81);
    wr(8'h01);
    cmp({4'h0, rst_out}, 8'h05);
    tick(40);
    cmp({4'h0, rst_out}, 8'h04);
    shut = 1'b1;
    tick(1);
    shut = 1'b0;
    cmp({4'h0, rst_out}, 8'h05);
    tick(40);
    wr(8'h02);
    cmp({4'h0, rst_out} & 8'h07, 8'h02);
    rd(16'h0CF9, 8'h80);
    cmp({6'h00, regs_def, rtc_out}, 8'h02);
    wait_rel;
    cmp(8'(cyc - c_wr >= 16 && cyc - c_wr <= 20), 8'h01);
    rd(16'h0CF9, 8'h00);
    good_req = 1'b0;
    tick(8);
    cmp({3'h0, oe, rst_out}, 8'h1A);
    strap_n = 1'b0;
    good_req = 1'b1;
    tick(8);
    cmp({7'h00, oe}, 8'h00);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(1);
    cmp({3'h0, oe, rst_out}, 8'h1A);
    finish_test;
  end
endmodule : tb
`default_nettype wire

// File: verilog/crg_top.sv
// Purpose: Clock and reset generation for a PCI to expansion bus bridge.
// Assumes: clk is the host clock; all other inputs are taken as synchronous
//          to it except power_good, which is synchronized here.
// Notes:   The PCI clock is clk divided by two; PCI work happens on the
//          one-cycle enable that marks its rising edge.
//
// Overview of operation
// - PCI clock output is a synchronous divide-by-two of the host clock.
// - Host clock input sources both the host clock output and the PCI clock.
// - PCI side inputs are sampled on every host clock rising edge, not only on PCI clock edges.
// - Real-time clock input is driven out gated for suspend refresh.
// - While power-good is low, CPU, PCI and expansion resets stay asserted.
// - Once power-good is high, CPU, PCI and expansion resets are released.
// - Power-good may change at any time and is synchronized before use.
// - CPU reset is asserted at power-up and on software hard reset request.
// - CPU reset changes only on a PCI clock rising edge.
// - A software hard reset returns internal registers to default values.
// - PCI reset stays asserted at least 1 ms after power-good rises.
// - A software hard reset holds PCI reset active at least 1 ms.
// - PCI reset may change with no alignment to the PCI clock.
// - A detected shutdown special cycle raises the CPU initialization output.
// - A soft reset written to port 0CF9h raises the CPU initialization output.
// - Expansion reset asserts at power-up and hard reset, at least 1 ms.
// - Test input sampled at power-good rise; active means all outputs float.
`timescale 1ns/100ps
`default_nettype none
`include "crg_regs.svh"

module crg_top #(
  parameter int RST_PCI_CYCLES = (`CRG_RST_MIN_US * `CRG_CLK_MHZ + 1) / 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Board inputs.
  input wire logic power_good,
  input wire logic tristate_test_in_n,
  input wire logic rtc_clock_in,
  // Shutdown special cycle decoded by the PCI target.
  input wire logic shutdown_cycle,
  // I/O access to the reset control port.
  input wire crg_pkg::crg_io_req_type io_req,
  output logic [7:0] io_rdata,
  // Clock outputs.
  output logic host_clock_out,
  output logic pci_clock_out,
  output logic rtc_clock_gated_out,
  // Reset outputs.
  output crg_pkg::crg_rst_out_type rst_out,
  // Register default reload for the rest of the bridge.
  output logic regs_default_out,
  // Output enable shared by every driven pin.
  output logic outputs_oe
);
  import crg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Derived counts.

  // A hard request lands between PCI edges, so it counts one edge more to
  // keep the full minimum.
  localparam logic [`CRG_CNT_W-1:0] HARD_LOAD = `CRG_CNT_W'(RST_PCI_CYCLES);
  localparam logic [7:0] RC_DEFAULT = `CRG_RC_RESET;
  localparam logic [`CRG_CNT_W-1:0] RST_LOAD =
    `CRG_CNT_W'(RST_PCI_CYCLES - 1);
  localparam logic [`CRG_INIT_W-1:0] INIT_LOAD =
    `CRG_INIT_W'(`CRG_INIT_PCI_CYCLES - 1);

  function automatic logic rc_hit(input crg_io_req_type req);
    rc_hit = (req.addr == `CRG_RC_ADDR);
  endfunction : rc_hit

  ////////////////////////////////////////////////////////////////////////////
  // State.

  crg_state_type st_ff;
  crg_state_type nxt_st;
  logic pci_edge;
  logic wr_hit;
  logic soft_req;
  logic hard_req;

  // Rising PCI clock edge occurs when the divided clock goes high.
  assign pci_edge = !st_ff.pci_clk;
  assign wr_hit = io_req.wr && rc_hit(io_req);
  assign soft_req = wr_hit && io_req.wdata[`CRG_RC_SOFT_BIT];
  assign hard_req = wr_hit && io_req.wdata[`CRG_RC_HARD_BIT];

  always_comb begin
    nxt_st = st_ff;
    // Two-stage synchronizer for the asynchronous power-good.
    nxt_st.pg_meta = power_good;
    nxt_st.pg_sync = st_ff.pg_meta;
    nxt_st.pci_clk = !st_ff.pci_clk;
    nxt_st.rtc_gated = rtc_clock_in && st_ff.rtc_en;
    nxt_st.rdata = 8'h00;
    if (io_req.rd && rc_hit(io_req)) begin
      nxt_st.rdata[`CRG_RC_RTC_EN_BIT] = st_ff.rtc_en;
      nxt_st.rdata[`CRG_RC_BUSY_BIT] = (st_ff.seq != CRG_RUN);
    end
    if (wr_hit) begin
      nxt_st.rtc_en = io_req.wdata[`CRG_RC_RTC_EN_BIT];
    end

    // Initialization pulse: shutdown cycle or soft request restarts it.
    if ((shutdown_cycle || soft_req) && st_ff.seq == CRG_RUN) begin
      nxt_st.rst.cpu_init_out = 1'b1;
      nxt_st.init_cnt = INIT_LOAD;
    end else if (pci_edge && st_ff.rst.cpu_init_out) begin
      if (st_ff.init_cnt == '0) begin
        nxt_st.rst.cpu_init_out = 1'b0;
      end else begin
        nxt_st.init_cnt = st_ff.init_cnt - `CRG_INIT_W'(1);
      end
    end

    if (pci_edge) begin
      nxt_st.pg_seen = st_ff.pg_sync;
    end

    unique case (st_ff.seq)
      CRG_OFF: begin
        nxt_st.rst.pci_reset_out_n = 1'b0;
        nxt_st.rst.expansion_bus_reset_out = 1'b1;
        nxt_st.rst.cpu_init_out = 1'b0;
        nxt_st.cnt = RST_LOAD;
        if (pci_edge) begin
          nxt_st.rst.cpu_reset_out = 1'b1;
        end
        if (pci_edge && st_ff.pg_sync && !st_ff.pg_seen) begin
          // Test strap is caught at the power-good rise.
          nxt_st.tristate = !tristate_test_in_n;
          nxt_st.seq = CRG_HOLD;
        end
      end
      CRG_HOLD, CRG_HARD: begin
        if (pci_edge) begin
          nxt_st.rst.cpu_reset_out = 1'b1;
          if (st_ff.cnt == '0) begin
            nxt_st.seq = CRG_RUN;
            nxt_st.rst.cpu_reset_out = 1'b0;
          end else begin
            nxt_st.cnt = st_ff.cnt - `CRG_CNT_W'(1);
          end
        end
        if (nxt_st.seq == CRG_RUN) begin
          // Released on the same clk as CPU reset, on a PCI clock rising edge.
          nxt_st.rst.pci_reset_out_n = 1'b1;
          nxt_st.rst.expansion_bus_reset_out = 1'b0;
        end
      end
      CRG_RUN: begin
        if (hard_req) begin
          // Hard reset wins over a soft request in the same write.
          nxt_st.seq = CRG_HARD;
          nxt_st.cnt = HARD_LOAD;
          nxt_st.rtc_en = RC_DEFAULT[`CRG_RC_RTC_EN_BIT];
          nxt_st.rst.cpu_init_out = 1'b0;
          nxt_st.rst.pci_reset_out_n = 1'b0;
          nxt_st.rst.expansion_bus_reset_out = 1'b1;
        end
      end
    endcase

    // Power-good loss overrides every other sequence.
    if (!st_ff.pg_sync) begin
      nxt_st.seq = CRG_OFF;
      // A short glitch must not leave the rise detector blind.
      nxt_st.pg_seen = 1'b0;
      if (pci_edge) begin
        // A release on this very edge is taken back at once.
        nxt_st.rst.cpu_reset_out = 1'b1;
      end
      nxt_st.rst.pci_reset_out_n = 1'b0;
      nxt_st.rst.expansion_bus_reset_out = 1'b1;
      nxt_st.rst.cpu_init_out = 1'b0;
      nxt_st.rtc_en = RC_DEFAULT[`CRG_RC_RTC_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '{
        seq: CRG_OFF,
        pg_meta: 1'b0,
        pg_sync: 1'b0,
        pg_seen: 1'b0,
        tristate: 1'b0,
        pci_clk: 1'b0,
        rtc_en: 1'b0,
        rtc_gated: 1'b0,
        cnt: '0,
        init_cnt: '0,
        rdata: 8'h00,
        rst: '{
          cpu_reset_out: 1'b1,
          pci_reset_out_n: 1'b0,
          expansion_bus_reset_out: 1'b1,
          cpu_init_out: 1'b0
        }
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The host clock passes straight through; only the PCI clock is divided.
  assign host_clock_out = clk;
  assign pci_clock_out = st_ff.pci_clk;
  assign rtc_clock_gated_out = st_ff.rtc_gated;
  assign rst_out = st_ff.rst;
  assign io_rdata = st_ff.rdata;
  assign regs_default_out = (st_ff.seq != CRG_RUN);
  assign outputs_oe = !st_ff.tristate;

endmodule : crg_top
`default_nettype wire
